// >>> rtl/bsfg_top.sv
/*
  Boot section flash guard: arming, lock decode, section decode, halt and
  concurrent-section busy, with an Avalon-MM register slave.
  Assumes a CPU that presents store and load strobes with the fetch address.
*/
//
// Contract
// [R1] Store from application section never starts programming.
// [R2] Boot section store may target any page.
// [R3] Boot-size fuses place the section boundary.
// [R4] Concurrent-section target keeps the CPU running.
// [R5] Halting-section target stalls CPU whole operation.
// [R6] Software avoids concurrent section while programming.
// [R7] Busy flag reads one while section blocked.
// [R8] Software clears busy before using concurrent section.
// [R9] Boot section always inside halting section.
// [R10] Two independent two-bit lock fields.
// [R11] Locks program anytime, clear by chip erase.
// [R12] General lock modes ignore store and load.
// [R13] Application lock field decode.
// [R14] Application lock blocks interrupts when vectors boot.
// [R15] Boot lock field decode.
// [R16] Boot lock blocks interrupts when vectors application.
// [R17] Lock bit one unprogrammed, zero programmed.
// [R18] Read-enable with store-enable clears busy.
// [R19] Store-enable arms for four cycles.
// [R20] Section limits are parameters.
// [R21] Forbidden access suppressed without halt.
`timescale 1ns/1ps
`include "bsfg_params.svh"

module bsfg_top #(
  parameter logic [15:0] BOOT_START_0 = 16'h7000,
  parameter logic [15:0] BOOT_START_1 = 16'h7800,
  parameter logic [15:0] BOOT_START_2 = 16'h7C00,
  parameter logic [15:0] BOOT_START_3 = 16'h7E00,
  parameter logic [15:0] HALT_START = 16'h7000,
  parameter int PROG_CYCLES = `BSFG_PROG_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [`BSFG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU side.
  input wire bsfg_pkg::bsfg_cpu_req_type cpu_req,
  output bsfg_pkg::bsfg_cpu_rsp_type cpu_rsp,
  // Configuration.
  input wire logic chip_erase,
  input wire logic ext_lock_en,
  input wire logic [3:0] ext_lock_bits,
  input wire logic [1:0] general_lock
);
  import bsfg_pkg::*;

  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  bsfg_state_type state;
  bsfg_op_type op;
  logic [2:0] arm_count;
  logic [31:0] prog_count;
  logic busy_flag;
  logic halt_target;
  logic [1:0] boot_size_fuses;
  logic vectors_in_boot;
  logic [1:0] app_lock_field;
  logic [1:0] boot_lock_field;
  logic avs_pending;

  // Bus write decode.
  logic wr_ctrl;
  logic wr_lock;
  logic wr_fuse;
  logic ctrl_store_en;
  logic [3:0] sw_lock_bits;
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == `BSFG_OFS_CTRL;
  assign wr_lock = avs_write && !avs_waitrequest && avs_address == `BSFG_OFS_LOCK;
  assign wr_fuse = avs_write && !avs_waitrequest && avs_address == `BSFG_OFS_FUSE;
  assign ctrl_store_en = wr_ctrl && avs_writedata[`BSFG_CTRL_STORE_EN];
  assign sw_lock_bits = avs_writedata[3:0];

  // Lock fields, each in its own cell.
  bsfg_lock_cell u_app_lock (
    .clk(clk),
    .rst_n(rst_n),
    .program_en(wr_lock || ext_lock_en),
    .program_bits((wr_lock ? sw_lock_bits[1:0] : 2'h3) &
                  (ext_lock_en ? ext_lock_bits[1:0] : 2'h3)),
    .chip_erase(chip_erase),
    .field(app_lock_field)
  ); // [R10] [R11]
  bsfg_lock_cell u_boot_lock (
    .clk(clk),
    .rst_n(rst_n),
    .program_en(wr_lock || ext_lock_en),
    .program_bits((wr_lock ? sw_lock_bits[3:2] : 2'h3) &
                  (ext_lock_en ? ext_lock_bits[3:2] : 2'h3)),
    .chip_erase(chip_erase),
    .field(boot_lock_field)
  ); // [R10] [R11]

  // Section decode.
  logic [15:0] boot_start;
  always_comb begin
    unique case (boot_size_fuses)
      2'b00: boot_start = BOOT_START_0;
      2'b01: boot_start = BOOT_START_1;
      2'b10: boot_start = BOOT_START_2;
      2'b11: boot_start = BOOT_START_3;
    endcase
  end // [R3] [R20]

  logic pc_in_boot;
  logic addr_in_boot;
  logic addr_in_halt;
  assign pc_in_boot = cpu_req.pc >= boot_start; // [R1]
  assign addr_in_boot = cpu_req.addr >= boot_start;
  assign addr_in_halt = cpu_req.addr >= HALT_START || addr_in_boot; // [R9]

  // Lock permissions; general lock modes play no part.
  logic store_forbidden;
  logic load_forbidden;
  assign store_forbidden = addr_in_boot ?
    !boot_lock_field[0] : !app_lock_field[0]; // [R13] [R15] [R12]
  assign load_forbidden = pc_in_boot ?
    (!addr_in_boot && !app_lock_field[1]) :
    (addr_in_boot && !boot_lock_field[1]); // [R13] [R15] [R12]

  logic store_go;
  assign store_go = cpu_req.store && state == BSFG_ARMED && pc_in_boot; // [R1] [R2]

  // Arming, operation and halt sequencing.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BSFG_IDLE;
      op <= BSFG_OP_NONE;
      arm_count <= 3'h0;
      prog_count <= 32'h0;
      halt_target <= 1'b0;
    end else begin
      unique case (state)
        BSFG_IDLE: begin
          if (ctrl_store_en && !avs_writedata[`BSFG_CTRL_READ_EN]) begin
            state <= BSFG_ARMED;
            arm_count <= `BSFG_ARM_CYCLES;
            op <= avs_writedata[`BSFG_CTRL_WRITE] ? BSFG_OP_WRITE :
                  avs_writedata[`BSFG_CTRL_ERASE] ? BSFG_OP_ERASE : BSFG_OP_FILL;
          end
        end
        BSFG_ARMED: begin
          if (store_go && op != BSFG_OP_FILL && !store_forbidden) begin
            state <= BSFG_BUSY;
            prog_count <= 32'h0;
            halt_target <= addr_in_halt; // [R4] [R5]
          end else if (store_go || arm_count == 3'h1) begin
            state <= BSFG_IDLE; // [R19] [R21]
            op <= BSFG_OP_NONE;
          end
          arm_count <= arm_count - 3'h1;
        end
        BSFG_BUSY: begin
          if (prog_count == PROG_LAST) begin
            state <= BSFG_IDLE;
            op <= BSFG_OP_NONE;
            halt_target <= 1'b0;
          end else begin
            prog_count <= prog_count + 32'h1;
          end
        end
        default: begin
          state <= BSFG_IDLE;
        end
      endcase
    end
  end

  // Concurrent-section busy flag; a new operation sets it over a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag <= 1'b0;
    end else if (state == BSFG_BUSY) begin
      busy_flag <= 1'b1; // [R7]
    end else if (ctrl_store_en && avs_writedata[`BSFG_CTRL_READ_EN]) begin
      busy_flag <= 1'b0; // [R18] [R8]
    end
  end

  // Configuration registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_size_fuses <= `BSFG_BOOT_SIZE_RESET;
      vectors_in_boot <= 1'b0;
    end else if (wr_fuse) begin
      boot_size_fuses <= avs_writedata[1:0]; // [R3]
      vectors_in_boot <= avs_writedata[2];
    end
  end

  // CPU response outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rsp <= '0;
    end else begin
      cpu_rsp.halt <= (state == BSFG_BUSY && halt_target && prog_count != PROG_LAST) ||
                      (store_go && op != BSFG_OP_FILL && !store_forbidden &&
                       addr_in_halt); // [R5] [R4] [R21]
      cpu_rsp.irq_block <= (!pc_in_boot && vectors_in_boot && !app_lock_field[1]) ||
                           (pc_in_boot && !vectors_in_boot && !boot_lock_field[1]); // [R14] [R16]
      cpu_rsp.load_block <= cpu_req.load && load_forbidden; // [R21]
      cpu_rsp.erase <= store_go && op == BSFG_OP_ERASE && !store_forbidden; // [R21]
      cpu_rsp.write <= store_go && op == BSFG_OP_WRITE && !store_forbidden; // [R21]
      cpu_rsp.fill <= store_go && op == BSFG_OP_FILL;
      cpu_rsp.addr <= cpu_req.addr; // [R2]
    end
  end

  // Avalon slave: one wait cycle, then the answer.
  logic [31:0] read_mux;
  always_comb begin
    read_mux = 32'h0;
    unique case (avs_address)
      `BSFG_OFS_CTRL: read_mux = {25'h0, busy_flag, 5'h0, state != BSFG_IDLE}; // [R7]
      `BSFG_OFS_LOCK: read_mux = {28'h0, boot_lock_field, app_lock_field};
      `BSFG_OFS_STATUS: read_mux = {28'h0, general_lock, state};
      `BSFG_OFS_FUSE: read_mux = {29'h0, vectors_in_boot, boot_size_fuses};
      default: read_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      avs_pending <= 1'b0;
    end else if ((avs_read || avs_write) && !avs_pending) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= read_mux;
      avs_pending <= 1'b1;
    end else begin
      avs_waitrequest <= 1'b1;
      avs_pending <= 1'b0;
    end
  end
endmodule

// >>> rtl/bsfg_params.svh
/*
  Constants for the boot section flash guard: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the design files and the checker.
*/
`ifndef BSFG_PARAMS_SVH
`define BSFG_PARAMS_SVH

`define BSFG_ADDR_W 4
`define BSFG_OFS_CTRL 4'h0
`define BSFG_OFS_LOCK 4'h1
`define BSFG_OFS_STATUS 4'h2
`define BSFG_OFS_FUSE 4'h3

`define BSFG_CTRL_STORE_EN 0
`define BSFG_CTRL_ERASE 1
`define BSFG_CTRL_WRITE 2
`define BSFG_CTRL_READ_EN 4
`define BSFG_CTRL_BUSY 6

`define BSFG_LOCK_RESET 4'hF
`define BSFG_LOCK_FREE 2'h3
`define BSFG_LOCK_NO_WRITE 2'h2
`define BSFG_LOCK_ALL 2'h0
`define BSFG_LOCK_NO_READ 2'h1

`define BSFG_ARM_CYCLES 3'h4
`define BSFG_CLK_HZ 40000000
`define BSFG_PROG_TIME_US 4500
`define BSFG_PROG_CYCLES (`BSFG_PROG_TIME_US * (`BSFG_CLK_HZ / 1000000))
`define BSFG_BOOT_SIZE_RESET 2'h0

`endif

// >>> rtl/bsfg_pkg.sv
/*
  Types of the boot section flash guard.
  Assumes the parameter header is on the include path.
*/
package bsfg_pkg;
  typedef enum logic [1:0] {
    BSFG_IDLE = 2'b00,
    BSFG_ARMED = 2'b01,
    BSFG_BUSY = 2'b10
  } bsfg_state_type;

  typedef enum logic [1:0] {
    BSFG_OP_FILL = 2'b00,
    BSFG_OP_ERASE = 2'b01,
    BSFG_OP_WRITE = 2'b10,
    BSFG_OP_NONE = 2'b11
  } bsfg_op_type;

  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] pc;
    logic [15:0] addr;
  } bsfg_cpu_req_type;

  typedef struct packed {
    logic halt;
    logic irq_block;
    logic load_block;
    logic erase;
    logic write;
    logic fill;
    logic [15:0] addr;
  } bsfg_cpu_rsp_type;
endpackage

// >>> rtl/bsfg_lock_cell.sv
/*
  One two-bit lock field held as nonvolatile-style bits.
  Assumes set strobes clear bits (program) and only chip erase or reset restores ones.
*/
`timescale 1ns/1ps
`include "bsfg_params.svh"

module bsfg_lock_cell (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Update strobes.
  input wire logic program_en,
  input wire logic [1:0] program_bits,
  input wire logic chip_erase,
  // Field value.
  output logic [1:0] field
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field <= 2'h3;
    end else if (chip_erase) begin
      field <= 2'h3; // [R11]
    end else if (program_en) begin
      field <= field & program_bits; // [R11] [R17]
    end
  end
endmodule

// >>> verif/bsfg_top_sva.sv
/* Port checker for the flash guard.
   Assumes a bind onto bsfg_top with its section and timing parameters. */
`timescale 1ns/1ps
`include "bsfg_params.svh"
module bsfg_top_sva #(
  parameter logic [15:0] BOOT_START_0 = 16'h7000,
  parameter logic [15:0] HALT_START = 16'h7000,
  parameter int PROG_CYCLES = `BSFG_PROG_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus.
  input wire logic [`BSFG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // CPU side.
  input wire bsfg_pkg::bsfg_cpu_req_type cpu_req,
  input wire bsfg_pkg::bsfg_cpu_rsp_type cpu_rsp
);
  import bsfg_pkg::*;
  logic [7:0] since_ctrl;
  int halt_len;
  logic op;
  assign op = cpu_rsp.erase || cpu_rsp.write || cpu_rsp.fill;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles since a control write was taken.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ctrl <= 8'hFF;
    end else if (avs_write && !avs_waitrequest && avs_address == `BSFG_OFS_CTRL) begin
      since_ctrl <= 8'h00;
    end else if (since_ctrl != 8'hFF) begin
      since_ctrl <= since_ctrl + 8'h01;
    end
  end
  // Counts consecutive halt cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_len <= 0;
    end else begin
      halt_len <= cpu_rsp.halt ? halt_len + 1 : 0;
    end
  end
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  app_store_a: assert property (cpu_req.store && cpu_req.pc < BOOT_START_0 |=> !op)
    else $error("store from application started an operation");
  arm_window_a: assert property (op |-> since_ctrl >= 8'h01 && since_ctrl <= 8'h04)
    else $error("operation outside arm window");
  halt_cause_a: assert property ((cpu_rsp.erase || cpu_rsp.write) |->
    cpu_rsp.halt == (cpu_rsp.addr >= HALT_START)) else $error("halt does not follow target");
  halt_start_a: assert property ($rose(cpu_rsp.halt) |-> cpu_rsp.erase || cpu_rsp.write)
    else $error("halt without operation");
  halt_len_a: assert property (cpu_rsp.halt |-> halt_len <= PROG_CYCLES + 1)
    else $error("halt too long");
  halt_full_a: assert property ($fell(cpu_rsp.halt) |-> halt_len >= PROG_CYCLES - 1)
    else $error("halt too short");
endmodule
bind bsfg_top bsfg_top_sva #(.BOOT_START_0(BOOT_START_0), .HALT_START(HALT_START),
  .PROG_CYCLES(PROG_CYCLES)) u_bsfg_top_sva (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));

// >>> verif/bsfg_cpu_model.sv
/* CPU core model issuing store and load requests.
   Assumes the bench calls issue only when the core may run. */
`timescale 1ns/1ps
module bsfg_cpu_model (
  // Clock.
  input wire logic clk,
  // Requests.
  output bsfg_pkg::bsfg_cpu_req_type cpu_req
);
  import bsfg_pkg::*;
  initial cpu_req = '0;
  // One-cycle request; the target lines then show garbage.
  task automatic issue(input logic st, input logic [15:0] pc, input logic [15:0] a);
    @(posedge clk);
    cpu_req <= '{store: st, load: !st, pc: pc, addr: a};
    @(posedge clk);
    cpu_req.store <= 1'b0;
    cpu_req.load <= 1'b0;
    cpu_req.addr <= ~a;
  endtask
endmodule

// >>> verif/tb_top.sv
/* Bench for the flash guard.
   Assumes a 40 MHz clock and a programming count of 20. */
`timescale 1ns/1ps
module tb_top;
  import bsfg_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, chip_erase, ext_lock_en;
  logic [3:0] avs_address, ext_lock_bits;
  logic [1:0] general_lock;
  logic [31:0] avs_writedata, avs_readdata, rd;
  bsfg_cpu_req_type cpu_req;
  bsfg_cpu_rsp_type cpu_rsp;
  int bad_count = 0, compares = 0, cyc = 0, n_op = 0, n_halt = 0, n_lb = 0, n_fill = 0;
  logic [15:0] op_addr;
  bsfg_top #(.PROG_CYCLES(20)) u_bsfg_top (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
    .chip_erase(chip_erase), .ext_lock_en(ext_lock_en), .ext_lock_bits(ext_lock_bits),
    .general_lock(general_lock));
  bsfg_cpu_model u_bsfg_cpu_model (.clk(clk), .cpu_req(cpu_req));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cpu_rsp.erase === 1'b1 || cpu_rsp.write === 1'b1) begin
      n_op++;
      op_addr = cpu_rsp.addr;
    end
    if (cpu_rsp.fill === 1'b1) n_fill++;
    if (cpu_rsp.halt === 1'b1) n_halt++;
    if (cpu_rsp.load_block === 1'b1) n_lb++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Arms with a control value, waits, stores, then checks and clears busy.
  task automatic st(input logic [31:0] c, input int gap, input logic [15:0] pc, a,
      input int e_op, e_halt);
    int o = n_op;
    int h = n_halt;
    bus(1'b1, 4'h0, c);
    repeat (gap) @(posedge clk);
    u_bsfg_cpu_model.issue(1'b1, pc, a);
    repeat (30) @(posedge clk);
    chk("ops", e_op, n_op - o);
    chk("halt cycles", e_halt, n_halt - h);
    if (e_op == 1) chk("op addr", {16'h0, a}, {16'h0, op_addr});
    bus(1'b0, 4'h0, 0);
    chk("busy", {31'h0, e_op == 1}, {31'h0, rd[6]});
    bus(1'b1, 4'h0, 32'h11);
    bus(1'b0, 4'h0, 0);
    chk("busy cleared", 32'h0, {31'h0, rd[6]});
  endtask
  // Moves the CPU to a new executing address and checks interrupt blocking.
  task automatic irq_chk(input logic [15:0] pc, input logic e);
    u_bsfg_cpu_model.issue(1'b0, pc, 16'h0300);
    @(posedge clk);
    chk("irq block", {31'h0, e}, {31'h0, cpu_rsp.irq_block});
  endtask
  task automatic lock_chk(input logic [3:0] e);
    bus(1'b0, 4'h1, 0);
    chk("lock", {28'h0, e}, rd & 32'hF);
  endtask
  task automatic t_regs;
    lock_chk(4'hF);
    bus(1'b0, 4'h2, 0);
    chk("status lock mode", 32'h2, (rd >> 2) & 32'h3);
    bus(1'b0, 4'h5, 0);
    chk("unmapped", 32'h0, rd);
    ext_lock_en <= 1'b1;
    ext_lock_bits <= 4'hB;
    @(posedge clk);
    ext_lock_en <= 1'b0;
    bus(1'b1, 4'h1, 32'hF);
    lock_chk(4'hB);
    bus(1'b1, 4'h1, 32'hE);
    lock_chk(4'hA);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    lock_chk(4'hF);
    $display("regs done");
  endtask
  task automatic t_ops;
    int l;
    st(32'h5, 0, 16'h0100, 16'h7200, 0, 0);
    st(32'h5, 0, 16'h7010, 16'h7200, 1, 20);
    st(32'h3, 0, 16'h7010, 16'h0200, 1, 0);
    l = n_fill;
    st(32'h1, 0, 16'h7010, 16'h7200, 0, 0);
    chk("fills", 1, n_fill - l);
    st(32'h5, 4, 16'h7010, 16'h0200, 0, 0);
    bus(1'b1, 4'h1, 32'hE);
    st(32'h5, 0, 16'h7010, 16'h0200, 0, 0);
    bus(1'b1, 4'h1, 32'h2);
    st(32'h3, 0, 16'h7010, 16'h7200, 0, 0);
    l = n_lb;
    u_bsfg_cpu_model.issue(1'b0, 16'h0100, 16'h7200);
    repeat (3) @(posedge clk);
    chk("load blocked", 1, n_lb - l);
    $display("ops done");
  endtask
  // Moves the boot boundary and the vectors, then checks stores and interrupt blocking.
  task automatic t_boot;
    general_lock <= 2'h1;
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    bus(1'b1, 4'h3, 32'h3);
    bus(1'b0, 4'h3, 0);
    chk("fuse", 32'h3, rd & 32'h7);
    st(32'h5, 0, 16'h7010, 16'h0200, 0, 0);
    st(32'h5, 0, 16'h7E10, 16'h0200, 1, 0);
    bus(1'b1, 4'h1, 32'h8);
    bus(1'b1, 4'h3, 32'h4);
    irq_chk(16'h0100, 1'b1);
    irq_chk(16'h7010, 1'b0);
    bus(1'b1, 4'h3, 32'h0);
    irq_chk(16'h7010, 1'b0);
    irq_chk(16'h0100, 1'b0);
    bus(1'b1, 4'h1, 32'h0);
    irq_chk(16'h7010, 1'b1);
    $display("boot done");
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    chip_erase = 1'b0;
    ext_lock_en = 1'b0;
    ext_lock_bits = 4'hF;
    general_lock = 2'h2;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ops();
    t_boot();
    report_and_stop();
  end
endmodule
